// ---- src/memory_protection_checker.sv ----
// Protection checker for core code and data accesses, with AXI4-Lite regs
// ------------------------------------------------------------------
// Summary of operation
// - Two complete protection sets, index 0 and 1.
// - Only the set picked by protection_set_select is checked.
// - Data part checks loads/stores, code part checks fetches.
// - Data part has four ranges with own permissions.
// - Code part has two ranges with own permissions.
// - Each range bounded by programmable lower and upper registers.
// - Per-range mode register selects allowed access kinds.
// - Both address and read/write type are restricted.
// - Out-of-range or wrong-type access is illegal.
// - Illegal access raises a trap to the core.
// - Illegal access can also notify the debug unit.
// ------------------------------------------------------------------
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module memory_protection_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core status
    input wire logic protection_set_select,
    // Data access request from core
    input wire mpu_pkg::daccess_t dreq,
    // Code access request from core
    input wire mpu_pkg::caccess_t creq,
    // Checked accesses toward memory
    output mpu_pkg::daccess_t dmem,
    output mpu_pkg::caccess_t cmem,
    // Traps and debug
    output logic data_trap,
    output logic code_trap,
    output logic debug_notify,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NS = mpu_pkg::NUM_SETS;
    localparam int NR = mpu_pkg::NUM_RANGE;
    localparam int ND = mpu_pkg::NUM_DRANGE;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mpu_pkg::range_t rng_q [NS][NR];
    mpu_pkg::range_t rng_d [NS][NR];
    logic [31:0] ctrl_q, ctrl_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] faddr_q, faddr_d;
    logic [31:0] finfo_q, finfo_d;
    mpu_pkg::daccess_t dmem_q, dmem_d;
    mpu_pkg::caccess_t cmem_q, cmem_d;
    logic dtrap_q, dtrap_d, ctrap_q, ctrap_d, dbg_q, dbg_d, irq_q, irq_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    // ------------------------------------------------------------------
    // Access checking
    // ------------------------------------------------------------------
    logic d_ok, c_ok, d_bad, c_bad, chk_en;
    mpu_pkg::range_t r;
    always_comb begin
        d_ok = 1'b0;
        c_ok = 1'b0;
        r = '0;
        chk_en = ctrl_q[mpu_pkg::CTRL_ENABLE];
        for (int i = 0; i < NR; i++) begin
            r = rng_q[protection_set_select][i];
            if (r.mode[mpu_pkg::MODE_EN] && dreq.addr >= r.lower
                && dreq.addr < r.upper && i < ND) begin
                if (dreq.write ? r.mode[mpu_pkg::MODE_WR]
                               : r.mode[mpu_pkg::MODE_RD]) begin
                    d_ok = 1'b1;
                end
            end
            if (r.mode[mpu_pkg::MODE_EN] && creq.addr >= r.lower
                && creq.addr < r.upper && i >= ND
                && r.mode[mpu_pkg::MODE_EXE]) begin
                c_ok = 1'b1;
            end
        end
        d_bad = chk_en && dreq.valid && !d_ok;
        c_bad = chk_en && creq.valid && !c_ok;
    end

    // Forward legal accesses, raise traps
    always_comb begin
        dmem_d = dreq;
        dmem_d.valid = dreq.valid && !d_bad;
        cmem_d = creq;
        cmem_d.valid = creq.valid && !c_bad;
        dtrap_d = d_bad;
        ctrap_d = c_bad;
        dbg_d = (d_bad || c_bad) && ctrl_q[mpu_pkg::CTRL_DEBUG];
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave and register file
    // ------------------------------------------------------------------
    logic do_wr, wr_hit, rd_hit;
    logic [11:0] rel;
    int si, ri;
    logic [31:0] wmask;
    always_comb begin
        rel = '0;
        si = 0;
        ri = 0;
        wr_hit = 1'b0;
        rd_hit = 1'b0;
        wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        aw_d = aw_q;
        w_d = w_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        rng_d = rng_q;
        // Catch address and data in either order
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        do_wr = aw_q && w_q && !bvalid_q;
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            rel = awaddr_q - mpu_pkg::OFS_SET_BASE;
            if (awaddr_q == mpu_pkg::OFS_CTRL) begin
                ctrl_d = (ctrl_q & ~wmask) | (wdata_q & wmask);
                wr_hit = 1'b1;
            end else if (awaddr_q == mpu_pkg::OFS_MASK) begin
                mask_d = (mask_q & ~wmask[1:0]) | (wdata_q[1:0] & wmask[1:0]);
                wr_hit = 1'b1;
            end else if (awaddr_q == mpu_pkg::OFS_STAT) begin
                wr_hit = 1'b1;
            end else if (awaddr_q >= mpu_pkg::OFS_SET_BASE) begin
                si = int'(rel / mpu_pkg::OFS_SET_STRIDE);
                ri = int'((rel % mpu_pkg::OFS_SET_STRIDE)
                          / mpu_pkg::OFS_RANGE_STRIDE);
                if (si < NS && ri < NR) begin
                    wr_hit = 1'b1;
                    unique case (rel[3:0])
                        mpu_pkg::OFS_LOWER[3:0]: rng_d[si][ri].lower =
                            (rng_q[si][ri].lower & ~wmask) | (wdata_q & wmask);
                        mpu_pkg::OFS_UPPER[3:0]: rng_d[si][ri].upper =
                            (rng_q[si][ri].upper & ~wmask) | (wdata_q & wmask);
                        mpu_pkg::OFS_MODE[3:0]: if (wstrb_q[0]) begin
                            rng_d[si][ri].mode = wdata_q[3:0];
                        end
                        default: wr_hit = 1'b0;
                    endcase
                end
            end
            bresp_d = wr_hit ? mpu_pkg::RESP_OKAY : mpu_pkg::RESP_SLVERR;
        end
        // Reads
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = mpu_pkg::ZERO32;
            rd_hit = 1'b1;
            rel = s_axi_araddr - mpu_pkg::OFS_SET_BASE;
            if (s_axi_araddr == mpu_pkg::OFS_CTRL) begin
                rdata_d = ctrl_q;
            end else if (s_axi_araddr == mpu_pkg::OFS_STAT) begin
                rdata_d[1:0] = stat_q;
            end else if (s_axi_araddr == mpu_pkg::OFS_MASK) begin
                rdata_d[1:0] = mask_q;
            end else if (s_axi_araddr == mpu_pkg::OFS_FADDR) begin
                rdata_d = faddr_q;
            end else if (s_axi_araddr == mpu_pkg::OFS_FINFO) begin
                rdata_d = finfo_q;
            end else if (s_axi_araddr >= mpu_pkg::OFS_SET_BASE) begin
                si = int'(rel / mpu_pkg::OFS_SET_STRIDE);
                ri = int'((rel % mpu_pkg::OFS_SET_STRIDE)
                          / mpu_pkg::OFS_RANGE_STRIDE);
                rd_hit = 1'b0;
                if (si < NS && ri < NR) begin
                    rd_hit = 1'b1;
                    unique case (rel[3:0])
                        mpu_pkg::OFS_LOWER[3:0]:
                            rdata_d = rng_q[si][ri].lower;
                        mpu_pkg::OFS_UPPER[3:0]:
                            rdata_d = rng_q[si][ri].upper;
                        mpu_pkg::OFS_MODE[3:0]:
                            rdata_d[3:0] = rng_q[si][ri].mode;
                        default: rd_hit = 1'b0;
                    endcase
                end
            end else begin
                rd_hit = 1'b0;
            end
            rresp_d = rd_hit ? mpu_pkg::RESP_OKAY : mpu_pkg::RESP_SLVERR;
        end
    end

    // Sticky status, set wins over write-one-to-clear; fault capture
    always_comb begin
        stat_d = stat_q;
        faddr_d = faddr_q;
        finfo_d = finfo_q;
        if (do_wr && awaddr_q == mpu_pkg::OFS_STAT && wstrb_q[0]) begin
            stat_d = stat_q & ~wdata_q[1:0];
        end
        if (d_bad) begin
            stat_d[mpu_pkg::STAT_DATA] = 1'b1;
            faddr_d = dreq.addr;
            finfo_d = {29'h0000_0000, dreq.write,
                       protection_set_select, 1'b0};
        end else if (c_bad) begin
            stat_d[mpu_pkg::STAT_CODE] = 1'b1;
            faddr_d = creq.addr;
            finfo_d = {29'h0000_0000, 1'b0, protection_set_select, 1'b1};
        end
        irq_d = |(stat_d & mask_q);
    end

    // Register all state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < NS; s++) begin
                for (int i = 0; i < NR; i++) begin
                    rng_q[s][i] <= '0;
                end
            end
            ctrl_q <= mpu_pkg::CTRL_RESET;
            stat_q <= '0;
            mask_q <= '0;
            faddr_q <= '0;
            finfo_q <= '0;
            dmem_q <= '0;
            cmem_q <= '0;
            dtrap_q <= 1'b0;
            ctrap_q <= 1'b0;
            dbg_q <= 1'b0;
            irq_q <= 1'b0;
            awaddr_q <= '0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            wdata_q <= '0;
            rdata_q <= '0;
            wstrb_q <= '0;
            bresp_q <= '0;
            rresp_q <= '0;
        end else begin
            rng_q <= rng_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            faddr_q <= faddr_d;
            finfo_q <= finfo_d;
            dmem_q <= dmem_d;
            cmem_q <= cmem_d;
            dtrap_q <= dtrap_d;
            ctrap_q <= ctrap_d;
            dbg_q <= dbg_d;
            irq_q <= irq_d;
            awaddr_q <= awaddr_d;
            aw_q <= aw_d;
            w_q <= w_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
        end
    end

    // Outputs
    assign dmem = dmem_q;
    assign cmem = cmem_q;
    assign data_trap = dtrap_q;
    assign code_trap = ctrap_q;
    assign debug_notify = dbg_q;
    assign irq = irq_q;
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : memory_protection_checker

// ---- src/mpu_pkg.sv ----
// Package: register map, field layout and carrier types of the protection checker
package mpu_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_SETS = 2;
    localparam int NUM_DRANGE = 4;
    localparam int NUM_CRANGE = 2;
    localparam int NUM_RANGE = NUM_DRANGE + NUM_CRANGE;
    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_FADDR = 12'h00C;
    localparam logic [11:0] OFS_FINFO = 12'h010;
    localparam logic [11:0] OFS_SET_BASE = 12'h100;
    localparam logic [11:0] OFS_SET_STRIDE = 12'h080;
    localparam logic [11:0] OFS_RANGE_STRIDE = 12'h010;
    localparam logic [11:0] OFS_LOWER = 12'h000;
    localparam logic [11:0] OFS_UPPER = 12'h004;
    localparam logic [11:0] OFS_MODE = 12'h008;
    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_DEBUG = 1;
    localparam int MODE_EN = 0;
    localparam int MODE_RD = 1;
    localparam int MODE_WR = 2;
    localparam int MODE_EXE = 3;
    localparam int STAT_DATA = 0;
    localparam int STAT_CODE = 1;
    localparam int STAT_W = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] lower;
        logic [31:0] upper;
        logic [3:0] mode;
    } range_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
    } daccess_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } caccess_t;
endpackage : mpu_pkg

// ---- testbench/mpc_assertions.sv ----
// Concurrent checks on the ports of the protection checker
`timescale 1ns/100ps
module mpc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core side
    input wire mpu_pkg::daccess_t dreq,
    input wire mpu_pkg::caccess_t creq,
    // Memory side and traps
    input wire mpu_pkg::daccess_t dmem,
    input wire mpu_pkg::caccess_t cmem,
    input wire logic data_trap,
    input wire logic code_trap,
    input wire logic debug_notify,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // ------------------------------------------------------------------
    // Access path
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    d_forward_a: assert property (
        dreq.valid |=> dmem.addr == $past(dreq.addr)
            && dmem.write == $past(dreq.write))
        else $error("data access not forwarded intact");
    d_verdict_a: assert property (
        dreq.valid |=> dmem.valid ^ data_trap)
        else $error("data access neither passed nor trapped");
    c_verdict_a: assert property (
        creq.valid |=> (cmem.valid ^ code_trap)
            && cmem.addr == $past(creq.addr))
        else $error("code fetch neither passed nor trapped");
    d_idle_a: assert property (
        !dreq.valid |=> !dmem.valid && !data_trap)
        else $error("data output without a request");
    c_idle_a: assert property (
        !creq.valid |=> !cmem.valid && !code_trap)
        else $error("code output without a request");
    trap_blocks_a: assert property (
        data_trap |-> !dmem.valid ##0 $past(dreq.valid))
        else $error("trapped data access reached memory");
    debug_with_trap_a: assert property (
        debug_notify |-> data_trap || code_trap)
        else $error("debug notify without a trap");
    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : mpc_checker

bind memory_protection_checker mpc_checker i_chk (.clk, .nrst, .dreq,
    .creq, .dmem, .cmem, .data_trap, .code_trap, .debug_notify,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);

// ---- testbench/core_model.sv ----
// Core model issuing code fetches and data accesses
`timescale 1ns/100ps
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Commands from the bench
    input wire logic go_d,
    input wire logic go_c,
    input wire logic [31:0] addr,
    input wire logic wr,
    // Requests toward the checker
    output mpu_pkg::daccess_t dreq,
    output mpu_pkg::caccess_t creq
);
    // One-cycle requests; idle address churns so stale values never match
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dreq <= '0;
            creq <= '0;
        end else begin
            dreq.valid <= go_d;
            dreq.addr <= go_d ? addr : ~dreq.addr;
            dreq.write <= go_d ? wr : ~dreq.write;
            creq.valid <= go_c;
            creq.addr <= go_c ? addr : ~creq.addr;
        end
    end
endmodule : core_model

// ---- testbench/memory_protection_checker_tb_top.sv ----
// Self-checking bench for the protection checker
`timescale 1ns/100ps
module memory_protection_checker_tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [31:0] M_R = 32'h0000_0003; // Enable and read
    localparam logic [31:0] M_RW = 32'h0000_0007; // Enable, read, write
    localparam logic [31:0] M_X = 32'h0000_0009; // Enable and execute
    logic clk, nrst, sel, go_d, go_c, wr, dbg;
    logic [31:0] addr, wdata, rdata, rd;
    mpu_pkg::daccess_t dreq, dmem;
    mpu_pkg::caccess_t creq, cmem;
    logic data_trap, code_trap, debug_notify, irq;
    logic [11:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int err_count, cmp_count;

    core_model i_core (.clk(clk), .nrst(nrst), .go_d(go_d), .go_c(go_c),
        .addr(addr), .wr(wr), .dreq(dreq), .creq(creq));
    memory_protection_checker i_dut (.clk(clk), .nrst(nrst),
        .protection_set_select(sel), .dreq(dreq), .creq(creq),
        .dmem(dmem), .cmem(cmem), .data_trap(data_trap),
        .code_trap(code_trap), .debug_notify(debug_notify), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic cmp_word(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, exp, input string m);
        cmp_word({31'h0, got}, {31'h0, exp}, m);
    endtask : cmp_bit

    // Bounded wait guard for every handshake loop
    task automatic guard(input int n);
        if (n > 200) begin
            err_count++;
            $display("Error at %0t: bus handshake timeout", $time);
            finish_test();
        end
    endtask : guard

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, pa, pw;
        int n;
        ta = 0;
        tw = 0;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            pa = awvalid && awready;
            pw = wvalid && wready;
            @(posedge clk);
            if (pa) begin
                awvalid <= 1'b0;
                ta = 1;
            end
            if (pw) begin
                wvalid <= 1'b0;
                tw = 1;
            end
            guard(n++);
        end
        // Ready rises in the same cycle as the answer, so the answer never waits
        @(posedge clk);
        bready <= 1'b1;
        do begin
            @(negedge clk);
            pa = bvalid;
            rsp = bresp;
            @(posedge clk);
            guard(n++);
        end while (!pa);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
        logic p;
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            p = arready;
            @(posedge clk);
            guard(n++);
        end while (!p);
        arvalid <= 1'b0;
        // Late ready leaves the answer waiting for one cycle
        @(posedge clk);
        rready <= 1'b1;
        do begin
            @(negedge clk);
            p = rvalid;
            d = rdata;
            rsp = rresp;
            @(posedge clk);
            guard(n++);
        end while (!p);
        rready <= 1'b0;
    endtask : axi_read

    task automatic set_range(input logic [11:0] s, r,
            input logic [31:0] lo, hi, m);
        logic [11:0] b;
        b = mpu_pkg::OFS_SET_BASE + s * mpu_pkg::OFS_SET_STRIDE
            + r * mpu_pkg::OFS_RANGE_STRIDE;
        axi_write(b + mpu_pkg::OFS_LOWER, lo);
        axi_write(b + mpu_pkg::OFS_UPPER, hi);
        axi_write(b + mpu_pkg::OFS_MODE, m);
    endtask : set_range

    // One core access, verdict looked at one cycle after the request
    task automatic acc(input logic code, input logic [31:0] a,
            input logic w, ok);
        @(posedge clk);
        go_d <= !code;
        go_c <= code;
        addr <= a;
        wr <= w;
        @(posedge clk);
        go_d <= 1'b0;
        go_c <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        cmp_bit(code ? cmem.valid : dmem.valid, ok, "access passed");
        cmp_bit(code ? code_trap : data_trap, !ok, "trap pulse");
        cmp_bit(debug_notify, !ok && dbg, "debug notify");
    endtask : acc
    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {nrst, sel, go_d, go_c, wr, dbg, awvalid, wvalid} = '0;
        {bready, arvalid, rready, addr, wdata, awaddr, araddr} = '0;
        wstrb = 4'hF;
        err_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // Reset state; checking off lets everything through
        axi_read(mpu_pkg::OFS_CTRL, rd);
        cmp_word(rd, mpu_pkg::CTRL_RESET, "ctrl reset");
        acc(0, 32'h0000_5000, 1, 1);
        // Enable with debug notify; no ranges means every access fails
        axi_write(mpu_pkg::OFS_CTRL, 32'h0000_0003);
        dbg = 1;
        acc(0, 32'h0000_1000, 0, 0);
        // Read-only data range, both boundaries and wrong type
        set_range(0, 0, 32'h0000_1000, 32'h0000_2000, M_R);
        acc(0, 32'h0000_1000, 0, 1);
        acc(0, 32'h0000_1FFC, 0, 1);
        acc(0, 32'h0000_2000, 0, 0);
        acc(0, 32'h0000_0FFC, 0, 0);
        acc(0, 32'h0000_1000, 1, 0);
        acc(1, 32'h0000_1000, 0, 0);
        // Remaining data ranges allow writes
        for (int r = 1; r < 4; r++) begin
            set_range(0, 12'(r), 32'(r) << 16, (32'(r) << 16) + 32'h100,
                M_RW);
            acc(0, (32'(r) << 16) + 32'h80, 1, 1);
        end
        // Code ranges: execute allowed in one, not in the other
        set_range(0, 4, 32'h0000_8000, 32'h0000_9000, M_X);
        set_range(0, 5, 32'h0000_A000, 32'h0000_B000, M_R);
        acc(1, 32'h0000_8000, 0, 1);
        acc(1, 32'h0000_A000, 0, 0);
        // Second set empty, then programmed read-write
        @(posedge clk);
        sel <= 1'b1;
        acc(0, 32'h0000_1000, 0, 0);
        set_range(1, 0, 32'h0000_1000, 32'h0000_1100, M_RW);
        acc(0, 32'h0000_1000, 1, 1);
        @(posedge clk);
        sel <= 1'b0;
        acc(0, 32'h0000_1000, 1, 0);
        // Fault address, interrupt mask and clear
        axi_read(mpu_pkg::OFS_FADDR, rd);
        cmp_word(rd, 32'h0000_1000, "fault address");
        axi_read(mpu_pkg::OFS_FINFO, rd);
        cmp_word(rd, 32'h0000_0004, "fault info");
        axi_write(mpu_pkg::OFS_MASK, 32'h0000_0001);
        repeat (2) @(negedge clk);
        cmp_bit(irq, 1'b1, "irq masked in");
        axi_write(mpu_pkg::OFS_STAT, 32'h0000_0003);
        repeat (2) @(negedge clk);
        cmp_bit(irq, 1'b0, "irq cleared");
        axi_read(mpu_pkg::OFS_STAT, rd);
        cmp_word(rd, mpu_pkg::ZERO32, "status cleared");
        // Debug notify off: trap alone; strobes keep the enable byte
        axi_write(mpu_pkg::OFS_CTRL, 32'h0000_0001);
        dbg = 0;
        acc(0, 32'h0000_0FFC, 0, 0);
        @(posedge clk);
        wstrb <= 4'hE;
        axi_write(mpu_pkg::OFS_CTRL, mpu_pkg::ZERO32);
        wstrb <= 4'hF;
        axi_read(mpu_pkg::OFS_CTRL, rd);
        cmp_word(rd, 32'h0000_0001, "ctrl strobes");
        // Unmapped register
        axi_read(12'hFFC, rd);
        cmp_word({30'h0, rsp}, {30'h0, mpu_pkg::RESP_SLVERR}, "resp");
        cmp_word(rd, mpu_pkg::ZERO32, "unmapped data");
        finish_test();
    end
endmodule : memory_protection_checker_tb_top
